// File: verilog/stack_sleep_regs.svh
// Timing, address and count constants for the stack sleep and wakeup control
`ifndef STACK_SLEEP_REGS_SVH
`define STACK_SLEEP_REGS_SVH
`define SYS_CLK_HZ 50000000
`define WAKE_CLK_HZ 4000
`define WAKE_HALF_CYC (`SYS_CLK_HZ / (2 * `WAKE_CLK_HZ))
`define WAKE_PULSES 4
`define CYC_PER_MS (`SYS_CLK_HZ / 1000)
`define ACK_WAIT_MS 40
`define ACK_WAIT_CYC (`ACK_WAIT_MS * `CYC_PER_MS)
`define SLEEP_WAIT_MS_R0 4
`define SLEEP_WAIT_MS_R1 8
`define SLEEP_WAIT_MS_R2 16
`define SLEEP_WAIT_MS_R3 32
`define WAKE_MAX_MS_8 63
`define WAKE_MAX_MS_14 100
`define ADDR_ALL 4'hf
`define WAKE_RX_EDGES 3'h3
`define FIRST_BYTE_BITS 4'h8
`define CNT_W 24
`endif

// File: verilog/stack_sleep_pkg.sv
// Types for the stack sleep and wakeup control
package stack_sleep_pkg;
	typedef enum logic [2:0] {ST_AWAKE, ST_WAIT, ST_ASLEEP, ST_WAKE_TX, ST_ACK_WAIT} pwr_state_e;
	typedef struct packed {
		logic sleep;
		logic wakeup;
		logic reset;
		logic meas;
		logic other;
		logic [3:0] addr;
	} cmd_s;
	typedef struct packed {
		logic ack;
		logic nak;
	} resp_s;
endpackage : stack_sleep_pkg

// File: verilog/stack_sleep_wakeup_control.sv
// Sleep, wakeup, checksum load and measurement launch control of one stack device
`timescale 1ns/10ps
`include "stack_sleep_regs.svh"

module stack_sleep_wakeup_control
	import stack_sleep_pkg::*;
#(
	parameter int WAKE_HALF = `WAKE_HALF_CYC,
	parameter int ACK_WAIT = `ACK_WAIT_CYC,
	parameter int SLEEP_R0 = `SLEEP_WAIT_MS_R0 * `CYC_PER_MS,
	parameter int SLEEP_R1 = `SLEEP_WAIT_MS_R1 * `CYC_PER_MS,
	parameter int SLEEP_R2 = `SLEEP_WAIT_MS_R2 * `CYC_PER_MS,
	parameter int SLEEP_R3 = `SLEEP_WAIT_MS_R3 * `CYC_PER_MS,
	parameter int WAKE_PULSES = `WAKE_PULSES
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic role_master,
	input wire logic role_top,
	input wire logic [3:0] dev_addr,
	input wire logic [1:0] rate_sel,
	input wire cmd_s cmd,
	input wire logic cmd_valid,
	input wire logic host_valid,
	input wire logic wdog_expire,
	input wire logic osc_fault,
	input wire logic scan_cont,
	input wire logic scan_tick,
	input wire logic sleep_fault,
	input wire logic cmd_last_bit,
	input wire logic results_written,
	input wire logic spi_cs,
	input wire logic spi_sck,
	input wire logic chain_clk,
	input wire logic wake_rx_p1,
	input wire logic wake_rx_p2,
	output logic asleep_ff,
	output resp_s resp_ff,
	output logic load_chk_ff,
	output logic launch_ff,
	output logic meas_busy_ff,
	output logic fwd_en_ff,
	output logic host_ignore_ff,
	output logic timeout_inh_ff,
	output logic wake_tx_p1_ff,
	output logic wake_tx_p2_ff
);

	pwr_state_e state_ff;
	logic [1:0] mst_sync_ff, top_sync_ff, sck_sync_ff, dck_sync_ff, rx1_sync_ff, rx2_sync_ff;
	logic is_master_ff, is_top_ff, sck_q_ff, dck_q_ff, rx1_q_ff, rx2_q_ff;
	logic rst_seen_ff, scan_at_sleep_ff, both_ports_ff, meas_armed_ff, wake_lvl_ff;
	logic [`CNT_W-1:0] cnt_ff;
	logic [2:0] rx_edges_ff;
	logic [3:0] pulse_cnt_ff, bit_cnt_ff;
	logic sleep_ok, sleep_bad, wake_ok, wake_bad, cancel, rx_edge, half_done;
	logic sck_fall, dck_fall, link_fall;
	logic [`CNT_W-1:0] sleep_len;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			mst_sync_ff <= 2'h0;
			top_sync_ff <= 2'h0;
			sck_sync_ff <= 2'h0;
			dck_sync_ff <= 2'h0;
			rx1_sync_ff <= 2'h0;
			rx2_sync_ff <= 2'h0;
		end else begin
			mst_sync_ff <= {mst_sync_ff[0], role_master};
			top_sync_ff <= {top_sync_ff[0], role_top};
			sck_sync_ff <= {sck_sync_ff[0], spi_sck};
			dck_sync_ff <= {dck_sync_ff[0], chain_clk};
			rx1_sync_ff <= {rx1_sync_ff[0], wake_rx_p1};
			rx2_sync_ff <= {rx2_sync_ff[0], wake_rx_p2};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			sck_q_ff <= 1'h0;
			dck_q_ff <= 1'h0;
			rx1_q_ff <= 1'h0;
			rx2_q_ff <= 1'h0;
			is_master_ff <= 1'h0;
			is_top_ff <= 1'h0;
		end else begin
			sck_q_ff <= sck_sync_ff[1];
			dck_q_ff <= dck_sync_ff[1];
			rx1_q_ff <= rx1_sync_ff[1];
			rx2_q_ff <= rx2_sync_ff[1];
			is_master_ff <= mst_sync_ff[1];
			is_top_ff <= top_sync_ff[1];
		end
	end

	assign sck_fall = sck_q_ff & ~sck_sync_ff[1];
	assign dck_fall = dck_q_ff & ~dck_sync_ff[1];
	assign link_fall = is_master_ff ? sck_fall : dck_fall;
	assign rx_edge = (rx1_q_ff ^ rx1_sync_ff[1]) | (rx2_q_ff ^ rx2_sync_ff[1]);

	////////////////////////////////////////////////////////////////////////////
	// Command decode
	assign sleep_ok = cmd_valid & cmd.sleep & (cmd.addr == `ADDR_ALL);
	assign sleep_bad = cmd_valid & cmd.sleep & (cmd.addr == dev_addr)
		& (cmd.addr != `ADDR_ALL);
	assign wake_ok = cmd_valid & cmd.wakeup & (cmd.addr == `ADDR_ALL) & is_master_ff;
	assign wake_bad = cmd_valid & cmd.wakeup & (cmd.addr != `ADDR_ALL) & is_master_ff;
	assign cancel = host_valid & ~(cmd_valid & cmd.sleep);

	always_comb begin
		unique case (rate_sel)
			2'h0: sleep_len = SLEEP_R0[`CNT_W-1:0];
			2'h1: sleep_len = SLEEP_R1[`CNT_W-1:0];
			2'h2: sleep_len = SLEEP_R2[`CNT_W-1:0];
			2'h3: sleep_len = SLEEP_R3[`CNT_W-1:0];
		endcase
	end

	assign half_done = (cnt_ff == WAKE_HALF[`CNT_W-1:0] - `CNT_W'h1);

	////////////////////////////////////////////////////////////////////////////
	// Power state machine
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			state_ff <= ST_AWAKE;
			cnt_ff <= `CNT_W'h0;
			pulse_cnt_ff <= 4'h0;
			wake_lvl_ff <= 1'h0;
			both_ports_ff <= 1'h0;
			scan_at_sleep_ff <= 1'h0;
			rx_edges_ff <= 3'h0;
		end else begin
			unique case (state_ff)
				ST_AWAKE: begin
					if (wdog_expire | osc_fault) begin
						state_ff <= ST_ASLEEP;
						scan_at_sleep_ff <= scan_cont;
						rx_edges_ff <= 3'h0;
					end else if (sleep_ok) begin
						state_ff <= ST_WAIT;
						cnt_ff <= `CNT_W'h0;
					end
				end
				ST_WAIT: begin
					if (wdog_expire | osc_fault) begin
						state_ff <= ST_ASLEEP;
						scan_at_sleep_ff <= scan_cont;
						rx_edges_ff <= 3'h0;
					end else if (sleep_ok) begin
						cnt_ff <= `CNT_W'h0;
					end else if (cancel) begin
						state_ff <= ST_AWAKE;
					end else if (cnt_ff >= sleep_len - `CNT_W'h1) begin
						state_ff <= ST_ASLEEP;
						scan_at_sleep_ff <= scan_cont;
						rx_edges_ff <= 3'h0;
					end else begin
						cnt_ff <= cnt_ff + `CNT_W'h1;
					end
				end
				ST_ASLEEP: begin
					cnt_ff <= `CNT_W'h0;
					pulse_cnt_ff <= 4'h0;
					wake_lvl_ff <= 1'h0;
					if (rx_edge) begin
						rx_edges_ff <= rx_edges_ff + 3'h1;
					end
					if (wake_ok) begin
						state_ff <= ST_WAKE_TX;
						both_ports_ff <= 1'h0;
					end else if (rx_edges_ff >= `WAKE_RX_EDGES) begin
						state_ff <= is_top_ff ? ST_ACK_WAIT : ST_WAKE_TX;
						both_ports_ff <= 1'h0;
					end else if (scan_at_sleep_ff & sleep_fault) begin
						state_ff <= is_top_ff ? ST_ACK_WAIT : ST_WAKE_TX;
						both_ports_ff <= ~is_master_ff;
					end else if (scan_at_sleep_ff & scan_tick) begin
						state_ff <= ST_AWAKE;
					end
				end
				ST_WAKE_TX: begin
					if (half_done) begin
						cnt_ff <= `CNT_W'h0;
						wake_lvl_ff <= ~wake_lvl_ff;
						if (wake_lvl_ff) begin
							pulse_cnt_ff <= pulse_cnt_ff + 4'h1;
						end
						if (wake_lvl_ff && pulse_cnt_ff == WAKE_PULSES[3:0] - 4'h1) begin
							state_ff <= ST_AWAKE;
						end
					end else begin
						cnt_ff <= cnt_ff + `CNT_W'h1;
					end
				end
				ST_ACK_WAIT: begin
					if (cnt_ff >= ACK_WAIT[`CNT_W-1:0] - `CNT_W'h1) begin
						state_ff <= ST_AWAKE;
					end else begin
						cnt_ff <= cnt_ff + `CNT_W'h1;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status and wakeup signal outputs
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			asleep_ff <= 1'h0;
			host_ignore_ff <= 1'h0;
			timeout_inh_ff <= 1'h0;
			wake_tx_p1_ff <= 1'h0;
			wake_tx_p2_ff <= 1'h0;
		end else begin
			asleep_ff <= (state_ff == ST_ASLEEP);
			host_ignore_ff <= (state_ff == ST_WAKE_TX);
			timeout_inh_ff <= (state_ff == ST_WAIT) | (state_ff == ST_WAKE_TX)
				| (state_ff == ST_ACK_WAIT) | (cmd_valid & cmd.sleep);
			wake_tx_p2_ff <= (state_ff == ST_WAKE_TX) & wake_lvl_ff;
			wake_tx_p1_ff <= (state_ff == ST_WAKE_TX) & wake_lvl_ff & both_ports_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Responses
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			resp_ff <= '0;
		end else begin
			resp_ff.ack <= (sleep_ok & is_top_ff)
				| ((state_ff == ST_ACK_WAIT)
				&& cnt_ff >= ACK_WAIT[`CNT_W-1:0] - `CNT_W'h1);
			resp_ff.nak <= sleep_bad | wake_bad;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Load checksum start
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			rst_seen_ff <= 1'h0;
			load_chk_ff <= 1'h0;
		end else begin
			rst_seen_ff <= 1'h1;
			load_chk_ff <= ~rst_seen_ff | (cmd_valid & cmd.reset);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Measurement launch and first byte forwarding
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			meas_armed_ff <= 1'h0;
			launch_ff <= 1'h0;
			meas_busy_ff <= 1'h0;
		end else begin
			launch_ff <= 1'h0;
			if (cmd_last_bit & cmd.meas) begin
				meas_armed_ff <= 1'h1;
			end else if (meas_armed_ff & link_fall) begin
				meas_armed_ff <= 1'h0;
				launch_ff <= 1'h1;
			end
			if (launch_ff) begin
				meas_busy_ff <= 1'h1;
			end else if (results_written) begin
				meas_busy_ff <= 1'h0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			bit_cnt_ff <= 4'h0;
			fwd_en_ff <= 1'h0;
		end else if (!spi_cs) begin
			bit_cnt_ff <= 4'h0;
			fwd_en_ff <= 1'h0;
		end else if (link_fall && bit_cnt_ff != `FIRST_BYTE_BITS) begin
			bit_cnt_ff <= is_master_ff ? bit_cnt_ff + 4'h1 : `FIRST_BYTE_BITS;
		end else if (bit_cnt_ff == `FIRST_BYTE_BITS) begin
			fwd_en_ff <= 1'h1;
		end
	end

endmodule : stack_sleep_wakeup_control

// File: test/stack_sleep_chk_asserts.sv
// Assertions on the sleep, wakeup and launch outputs
`timescale 1ns/10ps
module stack_sleep_chk
	import stack_sleep_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic role_top,
	input wire logic role_master,
	input wire logic [3:0] dev_addr,
	input wire cmd_s cmd,
	input wire logic cmd_valid,
	input wire logic results_written,
	input wire resp_s resp_ff,
	input wire logic load_chk_ff,
	input wire logic launch_ff,
	input wire logic meas_busy_ff,
	input wire logic timeout_inh_ff,
	input wire logic wake_tx_p2_ff,
	input wire logic host_ignore_ff
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	wire logic bc = cmd_valid && cmd.addr == 4'hf;
	//////////////////////////////////////////////////
	a_sleep_ack: assert property (bc && cmd.sleep && role_top |=> resp_ff.ack)
		else $error("sleep ack missing");
	a_sleep_nak: assert property (cmd_valid && cmd.sleep && cmd.addr == dev_addr
		&& !bc |=> resp_ff.nak)
		else $error("sleep nak missing");
	a_wake_nak: assert property (cmd_valid && cmd.wakeup && !bc
		&& role_master |=> resp_ff.nak)
		else $error("wakeup nak missing");
	a_sleep_inh: assert property (bc && cmd.sleep |=> timeout_inh_ff)
		else $error("timeout not inhibited");
	a_reset_load: assert property (cmd_valid && cmd.reset |-> ##[1:3] load_chk_ff)
		else $error("no checksum load");
	a_launch_busy: assert property (launch_ff |=> meas_busy_ff)
		else $error("busy not set");
	a_busy_hold: assert property (meas_busy_ff && !results_written |=> meas_busy_ff)
		else $error("busy ended early");
	a_tx_ignore: assert property (wake_tx_p2_ff |-> host_ignore_ff)
		else $error("host port not ignored");
	c_sleep: cover property (bc && cmd.sleep);
	c_wake_tx: cover property ($rose(wake_tx_p2_ff));
	c_launch: cover property (launch_ff);
endmodule : stack_sleep_chk

// File: test/stack_far_model.sv
// Far side model: host link clocks, chip select and neighbour wakeup signal
`timescale 1ns/10ps
module stack_far_model (
	output logic spi_cs,
	output logic spi_sck,
	output logic chain_clk,
	output logic wake_rx_p1,
	output logic wake_rx_p2,
	input wire logic sys_clk
);
	initial begin
		spi_cs = 0;
		spi_sck = 1;
		chain_clk = 1;
		wake_rx_p1 = 0;
		wake_rx_p2 = 0;
	end
	//////////////////////////////////////////////////
	// Link clocks run only inside a frame, edges on falling system clock
	task frame(input int n);
		@(negedge sys_clk);
		spi_cs = 1;
		repeat (n) begin
			repeat (4) @(negedge sys_clk);
			spi_sck = 0;
			chain_clk = 0;
			repeat (4) @(negedge sys_clk);
			spi_sck = 1;
			chain_clk = 1;
		end
		@(negedge sys_clk);
		spi_cs = 0;
	endtask : frame
	task wake(input int n, input logic port2);
		repeat (n) begin
			repeat (4) @(negedge sys_clk);
			if (port2) begin
				wake_rx_p2 = !wake_rx_p2;
			end else begin
				wake_rx_p1 = !wake_rx_p1;
			end
		end
		repeat (4) @(negedge sys_clk);
		wake_rx_p1 = 0;
		wake_rx_p2 = 0;
	endtask : wake
endmodule : stack_far_model

// File: test/stack_sleep_wakeup_control_tb_top.sv
// Self-checking bench of the stack sleep and wakeup control
`timescale 1ns/10ps
module stack_sleep_wakeup_control_tb_top
	import stack_sleep_pkg::*;
;
	localparam logic [4:0] K_SLP = 5'h10, K_WAK = 5'h08, K_RST = 5'h04;
	localparam int EV_HOST = 0, EV_WDOG = 1, EV_OSC = 2, EV_TICK = 3, EV_FLT = 4, EV_RES = 5;
	logic sys_clk = 0, rst_b = 0, role_master = 1, role_top = 1, scan_cont = 0, lc;
	logic cmd_last_bit = 0, cmd_valid = 0, wake_rx_p2;
	logic [5:0] ev = 6'h00;
	logic spi_cs, spi_sck, chain_clk, wake_rx_p1, asleep_ff, load_chk_ff, launch_ff;
	logic meas_busy_ff, fwd_en_ff, host_ignore_ff, timeout_inh_ff, wake_tx_p1_ff, wake_tx_p2_ff;
	logic [3:0] dev_addr = 4'h3;
	logic [1:0] rate_sel = 2'h0;
	logic [31:0] rnd = 32'hd56b;
	cmd_s cmd = '0;
	resp_s resp_ff, r;
	int err_count = 0, n_checks = 0, n, p1, p2, ak, hi, len, nl, nf;
	always #10 sys_clk = !sys_clk;
	stack_sleep_wakeup_control #(.WAKE_HALF(4), .ACK_WAIT(20), .SLEEP_R0(10), .SLEEP_R1(20),
		.SLEEP_R2(30), .SLEEP_R3(40), .WAKE_PULSES(4)) stack_sleep_wakeup_control_i (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.role_master(role_master),
		.role_top(role_top),
		.dev_addr(dev_addr),
		.rate_sel(rate_sel),
		.cmd(cmd),
		.cmd_valid(cmd_valid),
		.host_valid(ev[EV_HOST]),
		.wdog_expire(ev[EV_WDOG]),
		.osc_fault(ev[EV_OSC]),
		.scan_cont(scan_cont),
		.scan_tick(ev[EV_TICK]),
		.sleep_fault(ev[EV_FLT]),
		.cmd_last_bit(cmd_last_bit),
		.results_written(ev[EV_RES]),
		.spi_cs(spi_cs),
		.spi_sck(spi_sck),
		.chain_clk(chain_clk),
		.wake_rx_p1(wake_rx_p1),
		.wake_rx_p2(wake_rx_p2),
		.asleep_ff(asleep_ff),
		.resp_ff(resp_ff),
		.load_chk_ff(load_chk_ff),
		.launch_ff(launch_ff),
		.meas_busy_ff(meas_busy_ff),
		.fwd_en_ff(fwd_en_ff),
		.host_ignore_ff(host_ignore_ff),
		.timeout_inh_ff(timeout_inh_ff),
		.wake_tx_p1_ff(wake_tx_p1_ff),
		.wake_tx_p2_ff(wake_tx_p2_ff)
	);
	stack_far_model stack_far_model_i (
		.spi_cs(spi_cs),
		.spi_sck(spi_sck),
		.chain_clk(chain_clk),
		.wake_rx_p1(wake_rx_p1),
		.wake_rx_p2(wake_rx_p2),
		.sys_clk(sys_clk)
	);
	always @(negedge sys_clk) begin
		if (launch_ff === 1) nl++;
		if (fwd_en_ff === 1) nf++;
	end
	//////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic int slp_len(input logic [1:0] rs);
		return 10 * (rs + 1);
	endfunction : slp_len
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			err_count++;
			$display("Error %s exp %0h seen %0h", nm, e, s);
		end
	endtask : chk
	task send(input logic [4:0] k, input logic [3:0] a);
		@(negedge sys_clk);
		cmd = {k, a};
		cmd_valid = 1;
		@(negedge sys_clk);
		cmd_valid = 0;
		r = resp_ff;
	endtask : send
	task pulse(input int b);
		@(negedge sys_clk);
		ev[b] = 1'b1;
		@(negedge sys_clk);
		ev[b] = 1'b0;
	endtask : pulse
	task wait_sleep(input logic v, input int lim);
		n = 0;
		while (asleep_ff !== v && n < lim) begin
			@(negedge sys_clk);
			n++;
		end
	endtask : wait_sleep
	task watch(input int cyc);
		logic q1, q2;
		{p1, p2, ak, hi, q1, q2} = '0;
		for (int i = 1; i <= cyc; i++) begin
			@(negedge sys_clk);
			if (wake_tx_p1_ff && !q1) p1++;
			if (wake_tx_p2_ff && !q2) p2++;
			if (resp_ff.ack === 1) ak = i;
			if (host_ignore_ff === 1) hi++;
			q1 = wake_tx_p1_ff;
			q2 = wake_tx_p2_ff;
		end
	endtask : watch
	task test_done;
		if (err_count == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done
	//////////////////////////////////////////////////
	initial begin
		#1000000;
		err_count++;
		test_done;
	end
	initial begin
		repeat (10) @(negedge sys_clk);
		rst_b = 1;
		@(negedge sys_clk);
		chk("powerup load", load_chk_ff, 1);
		repeat (4) @(negedge sys_clk);
		send(K_RST, 4'hf);
		lc = load_chk_ff;
		repeat (3) @(negedge sys_clk) if (load_chk_ff === 1) lc = 1;
		chk("reset load", lc, 1);
		for (int k = 0; k < 4; k++) begin
			rate_sel = k[1:0];
			len = slp_len(rate_sel);
			rnd = lfsr(rnd);
			dev_addr = {1'b0, rnd[2:0]};
			scan_cont = rnd[6];
			send(K_SLP, dev_addr);
			chk("sleep nak", r.nak, 1);
			send(K_SLP, 4'hf);
			chk("sleep ack", r.ack, 1);
			chk("timeout inh", timeout_inh_ff, 1);
			repeat (1 + rnd[5:3]) @(negedge sys_clk);
			pulse(EV_HOST);
			repeat (len + 5) @(negedge sys_clk);
			chk("sleep cancel", asleep_ff, 0);
			send(K_SLP, 4'hf);
			repeat (5) @(negedge sys_clk);
			send(K_SLP, 4'hf);
			wait_sleep(1, len + 10);
			chk("sleep restart", n >= len - 3 && n <= len + 3, 1);
			role_top = 0;
			send(K_WAK, 4'h5);
			chk("wake nak", r.nak, 1);
			chk("still asleep", asleep_ff, 1);
			send(K_WAK, 4'hf);
			watch(80);
			chk("wake pulses", p2, 4);
			chk("single port", p1, 0);
			chk("ignore span", hi, 2 * 4 * 4);
			chk("awake", asleep_ff, 0);
			role_top = 1;
			repeat (5) @(negedge sys_clk);
		end
		role_master = 0;
		pulse(EV_WDOG);
		wait_sleep(1, 10);
		chk("wdog sleep", asleep_ff, 1);
		stack_far_model_i.wake(3, rnd[7]);
		watch(40);
		chk("rx wake", asleep_ff, 0);
		chk("top ack", ak > 0 && ak <= 25 && p2 == 0, 1);
		role_top = 0;
		scan_cont = 1;
		pulse(EV_OSC);
		wait_sleep(1, 10);
		chk("osc sleep", asleep_ff, 1);
		pulse(EV_FLT);
		watch(60);
		chk("fault both ports", p1 == 4 && p2 == 4, 1);
		chk("fault ignore", hi, 2 * 4 * 4);
		pulse(EV_WDOG);
		wait_sleep(1, 10);
		pulse(EV_TICK);
		wait_sleep(0, 10);
		chk("scan wake", asleep_ff, 0);
		role_master = 1;
		repeat (5) @(negedge sys_clk);
		{nl, nf} = '0;
		cmd = {5'h02, 4'h0};
		cmd_last_bit = 1;
		@(negedge sys_clk);
		cmd_last_bit = 0;
		repeat (5) @(negedge sys_clk);
		chk("launch early", nl, 0);
		stack_far_model_i.frame(7);
		chk("launch once", nl, 1);
		chk("fwd short", nf, 0);
		stack_far_model_i.frame(8);
		@(negedge sys_clk);
		chk("fwd byte", nf > 0 && nl == 1 && fwd_en_ff === 0, 1);
		repeat (rnd[3:0]) @(negedge sys_clk);
		chk("busy", meas_busy_ff, 1);
		pulse(EV_RES);
		@(negedge sys_clk);
		chk("busy end", meas_busy_ff, 0);
		test_done;
	end
endmodule : stack_sleep_wakeup_control_tb_top
bind stack_sleep_wakeup_control stack_sleep_chk stack_sleep_chk_i (
	.sys_clk(sys_clk),
	.rst_b(rst_b),
	.role_top(role_top),
	.role_master(role_master),
	.dev_addr(dev_addr),
	.cmd(cmd),
	.cmd_valid(cmd_valid),
	.results_written(results_written),
	.resp_ff(resp_ff),
	.load_chk_ff(load_chk_ff),
	.launch_ff(launch_ff),
	.meas_busy_ff(meas_busy_ff),
	.timeout_inh_ff(timeout_inh_ff),
	.wake_tx_p2_ff(wake_tx_p2_ff),
	.host_ignore_ff(host_ignore_ff)
);
